//--- verilog/tccr_pkg.sv
/*
  Constants, types and register map of the timer capture/compare block.
  Assumes a 32-bit APB master and one 25 MHz clock.
*/
package tccr_pkg;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CC0   = 8'h00;
  localparam logic [7:0]  ADDR_CC1   = 8'h04;
  localparam logic [7:0]  ADDR_CNT   = 8'h08;
  localparam logic [7:0]  ADDR_CTRL  = 8'h0C;
  localparam logic [7:0]  ADDR_EDGE  = 8'h10;

  // Widths
  localparam int          CNT_W      = 16;
  localparam int          CTRL_W     = 8;
  localparam int          EDGE_W     = 4;

  // Reset and idle values
  localparam logic [15:0] CC_RST     = 16'h0000;
  localparam logic [15:0] CNT_IDLE   = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [3:0]  EDGE_RST   = 4'h0;

  // Edge select codes, two bits per trigger input
  localparam logic [1:0]  EDGE_NONE  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_FALL  = 2'h2;
  localparam logic [1:0]  EDGE_BOTH  = 2'h3;

  // Operating modes, in control field order
  typedef enum logic [2:0] {
    MODE_INTERVAL,
    MODE_EVENT,
    MODE_TRIGGER,
    MODE_ONESHOT,
    MODE_PWM,
    MODE_FREERUN,
    MODE_PULSEWIDTH
  } tccr_mode_e;

  // Control register layout, MSB first
  typedef struct packed {
    logic [1:0] outEnable;
    logic [1:0] captureSelect;
    tccr_mode_e mode;
    logic       countEnable;
  } tccr_ctrl_s;

endpackage : tccr_pkg

//--- verilog/tccr_top.sv
/*
  Timer with two capture/compare registers and a counter read buffer,
  reached over APB with zero wait states.
  Assumes trigger inputs are synchronous to clk; the timer counts every clk.
*/
`timescale 1ns/100ps

// Behaviour
// - Register 0 is capture or compare by select bit only in free-running mode.
// - Register 1 is capture or compare by select bit only in free-running mode.
// - Both registers are 16-bit words, usable while running, reset to zero.
// - Writes to register 0 are accepted while counting is enabled.
// - Counter equal to buffer 0 pulses interrupt 0, toggles output 0 if enabled.
// - In cycle modes the counter clears when it equals buffer 0.
// - Free-running capture: valid edge on trigger 0 copies counter to register 0.
// - Pulse-width mode: trigger 0 edge captures into register 0, clears counter.
// - A read colliding with a capture into register 0 returns a clean value.
// - Update is immediate or batched by mode; immediate in pulse-width mode.
// - Writes to register 1 are accepted while counting is enabled.
// - Counter equal to buffer 1 pulses interrupt 1, toggles output 1 if enabled.
// - Free-running capture: valid edge on trigger 1 copies counter to register 1.
// - Pulse-width mode: trigger 1 edge captures into register 1, clears counter.
// - A read colliding with a capture into register 1 returns a clean value.
// - Read buffer is read-only and returns the live count while enabled.
// - With counting disabled the read buffer reads zero; counter holds all ones.
// - After reset the read buffer reads zero.
// - Counter starts at all ones; the wrap to zero raises no match.
// - Batched update loads both buffers on match 0, only after a register 1 write.
// - Edge select per trigger: none, rising, falling or both.
module tccr_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger inputs
  input  wire logic        triggerIn0,
  input  wire logic        triggerIn1,
  // Timer outputs and interrupts
  output logic             timerOut0,
  output logic             timerOut1,
  output logic             matchIrq0,
  output logic             matchIrq1
);

  tccr_pkg::tccr_ctrl_s    ctrl;
  tccr_pkg::tccr_ctrl_s    next_ctrl;
  logic [3:0]              edgeSel;
  logic [3:0]              next_edgeSel;
  logic [15:0]             counter;
  logic [15:0]             next_counter;
  logic                    fresh;
  logic                    next_fresh;
  logic                    wrapped;
  logic                    next_wrapped;
  logic                    pending;
  logic                    next_pending;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;
  logic [15:0]             cc       [2];
  logic [15:0]             compBuf  [2];
  logic [1:0]              trigIn;
  logic [1:0]              trigPrev;
  logic [1:0]              edgeHit;
  logic [1:0]              capEn;
  logic [1:0]              cmpEn;
  logic [1:0]              capEv;
  logic [1:0]              match;
  logic [1:0]              wrCc;
  logic [1:0]              outQ;
  logic                    setup;
  logic                    access;
  logic                    cycleMode;
  logic                    batchMode;
  logic                    clearEv;
  logic                    mapped;

  assign trigIn = {triggerIn1, triggerIn0};

  // Bus decode; no wait states, so pready is constant high
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wrCc[0] = access && pwrite && (paddr == tccr_pkg::ADDR_CC0);
  assign wrCc[1] = access && pwrite && (paddr == tccr_pkg::ADDR_CC1);

  always_comb
  begin
    mapped = (paddr == tccr_pkg::ADDR_CC0) || (paddr == tccr_pkg::ADDR_CC1) ||
             (paddr == tccr_pkg::ADDR_CNT) || (paddr == tccr_pkg::ADDR_CTRL) ||
             (paddr == tccr_pkg::ADDR_EDGE);
  end

  // Mode decode
  always_comb
  begin
    cycleMode = 1'b0;
    batchMode = 1'b0;
    unique case (ctrl.mode)
      tccr_pkg::MODE_INTERVAL,
      tccr_pkg::MODE_EVENT,
      tccr_pkg::MODE_ONESHOT:    cycleMode = 1'b1;
      tccr_pkg::MODE_TRIGGER,
      tccr_pkg::MODE_PWM:
      begin
        cycleMode = 1'b1;
        batchMode = 1'b1;
      end
      tccr_pkg::MODE_FREERUN,
      tccr_pkg::MODE_PULSEWIDTH: cycleMode = 1'b0;
      default:                   cycleMode = 1'b1;
    endcase
  end

  // Per-channel capture/compare logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : gChan
      logic [15:0] next_cc;
      logic [15:0] next_buf;
      logic        next_out;
      logic [1:0]  sel;

      assign sel = edgeSel[2*ch +: 2];

      always_comb
      begin
        unique case (sel)
          tccr_pkg::EDGE_RISE: edgeHit[ch] = trigIn[ch] && !trigPrev[ch];
          tccr_pkg::EDGE_FALL: edgeHit[ch] = !trigIn[ch] && trigPrev[ch];
          tccr_pkg::EDGE_BOTH: edgeHit[ch] = trigIn[ch] != trigPrev[ch];
          tccr_pkg::EDGE_NONE: edgeHit[ch] = 1'b0;
        endcase
        capEn[ch] = (ctrl.mode == tccr_pkg::MODE_PULSEWIDTH) ||
                    ((ctrl.mode == tccr_pkg::MODE_FREERUN) && ctrl.captureSelect[ch]);
        cmpEn[ch] = !capEn[ch];
        capEv[ch] = ctrl.countEnable && capEn[ch] && edgeHit[ch];
        // Start state and plain wrap are not compare events
        match[ch] = ctrl.countEnable && cmpEn[ch] && !fresh && !wrapped &&
                    (counter == compBuf[ch]);
        // Capture wins over a software write in the same cycle
        if (capEv[ch])
          next_cc = counter;
        else if (wrCc[ch])
          next_cc = pwdata[15:0];
        else
          next_cc = cc[ch];
        if (!ctrl.countEnable || !batchMode || (match[0] && pending))
          next_buf = cc[ch];
        else
          next_buf = compBuf[ch];
        next_out = outQ[ch] ^ (match[ch] && ctrl.outEnable[ch]);
      end

      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          cc[ch]       <= tccr_pkg::CC_RST;
          compBuf[ch]  <= tccr_pkg::CC_RST;
          outQ[ch]     <= 1'b0;
          trigPrev[ch] <= 1'b0;
        end
        else
        begin
          cc[ch]       <= next_cc;
          compBuf[ch]  <= next_buf;
          outQ[ch]     <= next_out;
          trigPrev[ch] <= trigIn[ch];
        end
      end
    end
  endgenerate

  assign timerOut0 = outQ[0];
  assign timerOut1 = outQ[1];
  // Event pulses last exactly the event cycle
  assign matchIrq0 = match[0] || capEv[0];
  assign matchIrq1 = match[1] || capEv[1];

  // Counter, start and batch state
  always_comb
  begin
    clearEv      = (cycleMode && match[0]) ||
                   ((ctrl.mode == tccr_pkg::MODE_PULSEWIDTH) && (capEv != 2'b00));
    next_fresh   = !ctrl.countEnable;
    next_wrapped = ctrl.countEnable && (counter == tccr_pkg::CNT_IDLE) && !clearEv;
    if (!ctrl.countEnable)
      next_counter = tccr_pkg::CNT_IDLE;
    else if (clearEv)
      next_counter = tccr_pkg::CNT_ZERO;
    else
      next_counter = counter + tccr_pkg::CNT_ONE;
    // Set wins over clear; a load while stopped counts as a transfer
    if (wrCc[1])
      next_pending = 1'b1;
    else if ((batchMode && match[0]) || !ctrl.countEnable)
      next_pending = 1'b0;
    else
      next_pending = pending;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      counter <= tccr_pkg::CNT_IDLE;
      fresh   <= 1'b1;
      wrapped <= 1'b0;
      pending <= 1'b0;
    end
    else
    begin
      counter <= next_counter;
      fresh   <= next_fresh;
      wrapped <= next_wrapped;
      pending <= next_pending;
    end
  end

  // Control registers
  always_comb
  begin
    next_ctrl    = ctrl;
    next_edgeSel = edgeSel;
    if (access && pwrite && (paddr == tccr_pkg::ADDR_CTRL))
      next_ctrl = tccr_pkg::tccr_ctrl_s'(pwdata[7:0]);
    if (access && pwrite && (paddr == tccr_pkg::ADDR_EDGE))
      next_edgeSel = pwdata[3:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl    <= tccr_pkg::tccr_ctrl_s'(tccr_pkg::CTRL_RST);
      edgeSel <= tccr_pkg::EDGE_RST;
    end
    else
    begin
      ctrl    <= next_ctrl;
      edgeSel <= next_edgeSel;
    end
  end

  // Read data sampled in the setup cycle: a same-edge capture lands after
  // the snapshot, so a read never sees a half-updated word
  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (setup)
    begin
      next_pslverr = !mapped;
      next_prdata  = 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          tccr_pkg::ADDR_CC0:  next_prdata[15:0] = cc[0];
          tccr_pkg::ADDR_CC1:  next_prdata[15:0] = cc[1];
          tccr_pkg::ADDR_CNT:
            next_prdata[15:0] = ctrl.countEnable ? counter : tccr_pkg::CNT_ZERO;
          tccr_pkg::ADDR_CTRL: next_prdata[7:0]  = ctrl;
          tccr_pkg::ADDR_EDGE: next_prdata[3:0]  = edgeSel;
          default:             next_prdata       = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_cnt_idle_read: assert property (
    (setup && !pwrite && paddr == tccr_pkg::ADDR_CNT && !ctrl.countEnable)
      |=> (prdata == 32'h0000_0000))
    else $error("count buffer not zero while stopped");

  a_cnt_live_read: assert property (
    (setup && !pwrite && paddr == tccr_pkg::ADDR_CNT && ctrl.countEnable)
      |=> (prdata[15:0] == $past(counter)))
    else $error("count buffer not live");

  a_stop_all_ones: assert property (
    !ctrl.countEnable ##1 !ctrl.countEnable |-> (counter == 16'hFFFF))
    else $error("stopped counter not all ones");

  a_cycle_clear: assert property (
    (match[0] && cycleMode && ctrl.countEnable && next_ctrl.countEnable)
      |=> (counter == 16'h0000))
    else $error("cycle match did not clear counter");

  a_out_toggle0: assert property (
    (matchIrq0 && cmpEn[0] && ctrl.outEnable[0]) |=> (timerOut0 != $past(timerOut0)))
    else $error("output 0 did not toggle");

  a_out_toggle1: assert property (
    (matchIrq1 && cmpEn[1] && ctrl.outEnable[1]) |=> (timerOut1 != $past(timerOut1)))
    else $error("output 1 did not toggle");

  a_cap0_value: assert property (
    capEv[0] |=> (cc[0] == $past(counter)))
    else $error("capture 0 value wrong");

  a_pw_clear: assert property (
    (capEv[0] && ctrl.mode == tccr_pkg::MODE_PULSEWIDTH && next_ctrl.countEnable)
      |=> (counter == 16'h0000) && (cc[0] == $past(counter)))
    else $error("pulse-width capture 0 wrong");

  a_cap1_value: assert property (
    capEv[1] |=> (cc[1] == $past(counter)))
    else $error("capture 1 value wrong");

  a_batch_load: assert property (
    (batchMode && match[0] && pending && ctrl.countEnable)
      |=> (compBuf[1] == $past(cc[1])) && (compBuf[0] == $past(cc[0])))
    else $error("batch transfer missing");

  a_batch_hold: assert property (
    (batchMode && ctrl.countEnable && !match[0] && $stable(ctrl))
      |=> $stable(compBuf[1]))
    else $error("batch buffer changed early");

  a_wrap_quiet: assert property (
    ($rose(ctrl.countEnable) ||
     (counter == 16'h0000 && $past(counter) == 16'hFFFF && !$past(clearEv)))
      |-> !(matchIrq0 && cmpEn[0]) && !(matchIrq1 && cmpEn[1]))
    else $error("match on start or wrap");

  a_irq_pulse: assert property (
    (matchIrq0 && !capEn[0] && cycleMode && ctrl.countEnable && compBuf[0] != 16'h0000)
      |=> !matchIrq0)
    else $error("match pulse too long");

  a_read_stable: assert property (access |=> $stable(prdata))
    else $error("read data moved in access");

  c_compare_match: cover property (matchIrq0 && timerOut0);
  c_capture_read:  cover property (capEv[0] && setup && paddr == tccr_pkg::ADDR_CC0);
  c_batch_xfer:    cover property (batchMode && match[0] && pending);
  c_pw_capture:    cover property (capEv[1] && ctrl.mode == tccr_pkg::MODE_PULSEWIDTH);

endmodule : tccr_top

//--- tb/tccr_trig_model.sv
/*
  Far-side model: drives both capture trigger pins, counts output toggles.
  Assumes its task is called just after a rising clk edge.
*/
`timescale 1ns/100ps
module tccr_trig_model (
  // Clock
  input  wire logic clk,
  // Trigger pins
  output logic      triggerIn0,
  output logic      triggerIn1,
  // Timer outputs
  input  wire logic timerOut0,
  input  wire logic timerOut1
);
  int   tog0;
  int   tog1;
  logic last0;
  logic last1;

  initial
  begin
    triggerIn0 = 1'b0;
    triggerIn1 = 1'b0;
    tog0       = 0;
    tog1       = 0;
    last0      = 1'b0;
    last1      = 1'b0;
  end

  // Levels move only after an edge, so the design never sees a half cycle
  task automatic drive(input logic v0, input logic v1);
    triggerIn0 <= v0;
    triggerIn1 <= v1;
  endtask : drive

  always @(posedge clk)
  begin
    last0 <= timerOut0;
    last1 <= timerOut1;
    if (timerOut0 !== last0)
      tog0 <= tog0 + 1;
    if (timerOut1 !== last1)
      tog1 <= tog1 + 1;
  end
endmodule : tccr_trig_model

//--- tb/tb_top.sv
/*
  Self-checking bench of the timer capture/compare block.
  Assumes zero-wait APB answers and the trigger model beside the design.
*/
`timescale 1ns/100ps
module tb_top;
  logic        clk;
  logic        rstn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        triggerIn0;
  logic        triggerIn1;
  logic        timerOut0;
  logic        timerOut1;
  logic        matchIrq0;
  logic        matchIrq1;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          totalChecks;
  int          gap;

  tccr_top uut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .triggerIn0(triggerIn0), .triggerIn1(triggerIn1), .timerOut0(timerOut0),
    .timerOut1(timerOut1), .matchIrq0(matchIrq0), .matchIrq1(matchIrq1));

  tccr_trig_model model (.clk(clk), .triggerIn0(triggerIn0), .triggerIn1(triggerIn1),
    .timerOut0(timerOut0), .timerOut1(timerOut1));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Waits up to 50 clocks for pready, so a stalled access ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] ctl(tccr_pkg::tccr_mode_e m, logic [1:0] sel, logic en);
    tccr_pkg::tccr_ctrl_s c;
    c = '{outEnable: 2'h3, captureSelect: sel, mode: m, countEnable: en};
    return {24'h000000, c};
  endfunction : ctl

  // Cycles between two interrupt 0 pulses, bounded
  task automatic irq_gap(output int g);
    int n;
    n = 0;
    while (matchIrq0 !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    g = 0;
    do
    begin
      @(posedge clk);
      g++;
    end
    while (matchIrq0 !== 1'b1 && g < 200);
    if (g >= 200)
    begin
      fails++;
      report_and_stop();
    end
  endtask : irq_gap

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk(tccr_pkg::ADDR_CC0, 32'h0, "cc0 reset");
    rd_chk(tccr_pkg::ADDR_CC1, 32'h0, "cc1 reset");
    rd_chk(tccr_pkg::ADDR_CNT, 32'h0, "cnt reset");
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped err");
    apb(1'b1, tccr_pkg::ADDR_CNT, 32'h1234);
    rd_chk(tccr_pkg::ADDR_CNT, 32'h0, "cnt read only");
    $display("test reset done");
  endtask : t_reset

  task automatic t_cycle;
    tccr_pkg::tccr_mode_e modes[5];
    int c0;
    int c1;
    int t0;
    int t1;
    modes = '{tccr_pkg::MODE_INTERVAL, tccr_pkg::MODE_EVENT, tccr_pkg::MODE_TRIGGER,
              tccr_pkg::MODE_ONESHOT, tccr_pkg::MODE_PWM};
    apb(1'b1, tccr_pkg::ADDR_CC0, 32'h3);
    apb(1'b1, tccr_pkg::ADDR_CC1, 32'h2);
    apb(1'b1, tccr_pkg::ADDR_EDGE, 32'hF);
    foreach (modes[i])
    begin
      apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(modes[i], 2'h0, 1'b0));
      apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(modes[i], 2'h0, 1'b1));
      irq_gap(gap);
      check(gap, 32'h4, "cycle length");
    end
    c0 = 0;
    c1 = 0;
    t0 = model.tog0;
    t1 = model.tog1;
    repeat (16)
    begin
      @(posedge clk);
      c0 += (matchIrq0 === 1'b1);
      c1 += (matchIrq1 === 1'b1);
    end
    check(c0, 32'h4, "irq0 pulses");
    check(c1, 32'h4, "irq1 pulses");
    check(model.tog0 - t0, 32'h4, "out0 toggles");
    check(model.tog1 - t1, 32'h4, "out1 toggles");
    model.drive(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    model.drive(1'b0, 1'b0);
    rd_chk(tccr_pkg::ADDR_CC0, 32'h3, "cc0 compare only");
    rd_chk(tccr_pkg::ADDR_CC1, 32'h2, "cc1 compare only");
    apb(1'b0, tccr_pkg::ADDR_CNT, 32'h0);
    check(32'(rd < 32'h4), 32'h1, "cnt live");
    apb(1'b1, tccr_pkg::ADDR_CNT, 32'h1234);
    check({31'h0, err}, 32'h0, "cnt write no err");
    apb(1'b0, tccr_pkg::ADDR_CNT, 32'h0);
    check(32'(rd < 32'h4), 32'h1, "cnt write ignored");
    apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(tccr_pkg::MODE_INTERVAL, 2'h0, 1'b1));
    apb(1'b1, tccr_pkg::ADDR_CC0, 32'h5);
    irq_gap(gap);
    irq_gap(gap);
    check(gap, 32'h6, "anytime write");
    apb(1'b1, tccr_pkg::ADDR_CC1, 32'h4);
    rd_chk(tccr_pkg::ADDR_CC1, 32'h4, "cc1 running write");
    apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(tccr_pkg::MODE_INTERVAL, 2'h0, 1'b0));
    rd_chk(tccr_pkg::ADDR_CNT, 32'h0, "cnt disabled");
    $display("test cycle done");
  endtask : t_cycle

  task automatic t_capture;
    apb(1'b1, tccr_pkg::ADDR_EDGE, 32'h9);
    apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(tccr_pkg::MODE_FREERUN, 2'h3, 1'b1));
    repeat (9) @(posedge clk);
    model.drive(1'b1, 1'b1);
    @(posedge clk);
    check(32'(matchIrq0), 32'h1, "capture irq0");
    check(32'(matchIrq1), 32'h0, "rise on fall select");
    repeat (3) @(posedge clk);
    model.drive(1'b1, 1'b0);
    rd_chk(tccr_pkg::ADDR_CC0, 32'h8, "cc0 capture");
    rd_chk(tccr_pkg::ADDR_CC1, 32'hC, "cc1 capture");
    apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(tccr_pkg::MODE_FREERUN, 2'h3, 1'b0));
    apb(1'b1, tccr_pkg::ADDR_EDGE, 32'h6);
    apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(tccr_pkg::MODE_PULSEWIDTH, 2'h0, 1'b1));
    repeat (20) @(posedge clk);
    model.drive(1'b0, 1'b1);
    rd_chk(tccr_pkg::ADDR_CC0, 32'h13, "cc0 pulse width");
    rd_chk(tccr_pkg::ADDR_CC1, 32'h13, "cc1 pulse width");
    apb(1'b0, tccr_pkg::ADDR_CNT, 32'h0);
    check(32'(rd < 32'h13), 32'h1, "counter cleared");
    $display("test capture done");
  endtask : t_capture

  task automatic t_batch;
    apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(tccr_pkg::MODE_PWM, 2'h0, 1'b0));
    apb(1'b1, tccr_pkg::ADDR_CC0, 32'h3);
    apb(1'b1, tccr_pkg::ADDR_CC1, 32'h1);
    apb(1'b1, tccr_pkg::ADDR_CTRL, ctl(tccr_pkg::MODE_PWM, 2'h0, 1'b1));
    apb(1'b1, tccr_pkg::ADDR_CC0, 32'h7);
    irq_gap(gap);
    irq_gap(gap);
    check(gap, 32'h4, "held without cc1 write");
    apb(1'b1, tccr_pkg::ADDR_CC1, 32'h1);
    irq_gap(gap);
    irq_gap(gap);
    check(gap, 32'h8, "batch transfer");
    $display("test batch done");
  endtask : t_batch

  initial
  begin
    fails       = 0;
    totalChecks = 0;
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_cycle();
    t_capture();
    t_batch();
    report_and_stop();
  end
endmodule : tb_top
